//--- bench/pxb_pad_model.sv
`timescale 1ns/100ps
module pxb_pad_model import pxb_pkg::*; (
  input wire logic clk_sys,
  input wire logic [NUM_PINS-1:0] pin_out,
  input wire logic [NUM_PINS-1:0] pin_oe_n,
  input wire logic [NUM_PINS-1:0] ext_drv,
  input wire logic [NUM_PINS-1:0] ext_val,
  input wire logic pull_off,
  output logic [NUM_PINS-1:0] pin_in
);
  logic [NUM_PINS-1:0] last_r;
  // device wins contention; a released pad with pull-ups off wanders
  always_comb begin
    for (int p = 0; p < NUM_PINS; p++) begin
      if (!pin_oe_n[p]) pin_in[p] = pin_out[p];
      else if (ext_drv[p]) pin_in[p] = ext_val[p];
      else pin_in[p] = pull_off ? ~last_r[p] : 1'b1;
    end
  end
  always_ff @(posedge clk_sys) last_r <= pin_in;
endmodule : pxb_pad_model

//--- bench/pxb_priority_pin_crossbar_asserts.sv
`timescale 1ns/100ps
module pxb_priority_pin_crossbar_asserts import pxb_pkg::*; #(
  parameter int NPIN = NUM_PINS,
  parameter int NSIG = NUM_SIGS
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire pxb_sfr_type sfr_bus,
  input wire logic [7:0] sfr_rdata,
  input wire logic [NPIN-1:0] pin_digital_mode,
  input wire pxb_periph_type periph,
  input wire logic [NSIG-1:0] periph_in,
  input wire logic [NPIN-1:0] pin_out,
  input wire logic [NPIN-1:0] pin_oe_n,
  input wire logic [NPIN-1:0] pin_assigned,
  input wire logic [NPIN-1:0] event_pin_level,
  input wire logic weak_pullup_off
);
  logic [7:0] sel0_s;
  logic [1:0] sel2_s;
  logic unmapped;
  logic tx_on;
  assign unmapped = !(sfr_bus.addr inside {ADDR_SEL0, ADDR_SEL1, ADDR_SEL2,
    ADDR_SKIP0, ADDR_SKIP1});
  assign tx_on = sel2_s[0] && sel0_s[SEL0_ASYNC_SER];
  // shadow copies taken from the register port itself
  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      sel0_s <= 8'h00;
      sel2_s <= 2'h0;
    end else if (sfr_bus.wr) begin
      if (sfr_bus.addr == ADDR_SEL0) sel0_s <= sfr_bus.wdata;
      if (sfr_bus.addr == ADDR_SEL2) sel2_s <= sfr_bus.wdata[7:6];
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  off_no_drive_a: assert property (!sel2_s[0] && !$past(sel2_s[0])
    |-> &pin_oe_n && pin_assigned == '0 && &periph_in)
    else $error("pins active with crossbar off");
  event_dig_a: assert property (
    (event_pin_level & ~$past(pin_digital_mode)) == '0)
    else $error("event level on analog pin");
  rdata_hold_a: assert property (!$past(sfr_bus.rd) |-> $stable(sfr_rdata))
    else $error("read data moved without a read");
  unmapped_read_a: assert property (sfr_bus.rd && unmapped
    |=> sfr_rdata == RDATA_UNMAPPED) else $error("unmapped read not zero");
  async_fixed_a: assert property (tx_on && $past(tx_on)
    && $past(pin_digital_mode[PIN_ASYNC_TX])
    |-> pin_assigned[5:4] == 2'b11
    && pin_out[PIN_ASYNC_TX] == $past(periph.level[SIG_ASYNC_TX]))
    else $error("async serial not on fixed pins");
  pullup_pin_a: assert property (sel2_s[1] == $past(sel2_s[1])
    |-> weak_pullup_off == sel2_s[1]) else $error("pull-up flag wrong");
  sel2_rdbk_a: assert property (
    sfr_bus.rd && sfr_bus.addr == ADDR_SEL2
    |=> sfr_rdata == {$past(sel2_s), 6'h00}) else $error("select 2 readback");
  sel0_rdbk_a: assert property (
    sfr_bus.rd && sfr_bus.addr == ADDR_SEL0
    |=> sfr_rdata == $past(sel0_s)) else $error("select 0 readback");
  tx_route_c: cover property (tx_on && pin_assigned[PIN_ASYNC_RX]);
  two_wire_c: cover property (sel2_s[0] && sel0_s[SEL0_TWO_WIRE]);
  unmapped_c: cover property (sfr_bus.rd && unmapped);
endmodule : pxb_priority_pin_crossbar_asserts
bind pxb_priority_pin_crossbar pxb_priority_pin_crossbar_asserts #(
  .NPIN(NPIN), .NSIG(NSIG)) u_pxb_priority_pin_crossbar_asserts (
  .clk_sys(clk_sys), .reset(reset), .sfr_bus(sfr_bus),
  .sfr_rdata(sfr_rdata), .pin_digital_mode(pin_digital_mode),
  .periph(periph), .periph_in(periph_in), .pin_out(pin_out),
  .pin_oe_n(pin_oe_n), .pin_assigned(pin_assigned),
  .event_pin_level(event_pin_level), .weak_pullup_off(weak_pullup_off));

//--- bench/pxb_priority_pin_crossbar_tb.sv
`timescale 1ns/100ps
module pxb_priority_pin_crossbar_tb import pxb_pkg::*; ;
  logic clk_sys, reset, spia_four_wire, spib_four_wire, weak_pullup_off;
  pxb_sfr_type sfr_bus;
  pxb_periph_type periph;
  logic [NUM_PINS-1:0] pin_output_mode, pin_digital_mode, gpio_latch;
  logic [NUM_PINS-1:0] pin_in, pin_out, pin_oe_n, pin_assigned;
  logic [NUM_PINS-1:0] event_pin_level, ext_drv, ext_val;
  logic [NUM_SIGS-1:0] periph_in;
  logic [7:0] sfr_rdata, s0, s1, s2, k0, k1, ab;
  logic [7:0] adr [5] = '{ADDR_SEL0, ADDR_SEL1, ADDR_SEL2, ADDR_SKIP0,
    ADDR_SKIP1};
  logic [7:0] msk [5] = '{8'hff, SEL1_MASK, SEL2_MASK, 8'hff, SKIP1_MASK};
  // corner cases: {four-wire a/b, sel0, sel1, sel2, skip0, skip1}
  logic [47:0] tbl [7] = '{48'h00_00_00_00_00_00, 48'h00_01_00_40_00_00,
    48'h00_ff_7f_40_00_00, 48'h02_ff_7f_40_00_00, 48'h01_fe_46_40_0c_00,
    48'h03_ff_3e_40_ff_7f, 48'h02_ff_7f_00_00_00};
  int bad_count, compares, seed, own [NUM_PINS];

  pxb_priority_pin_crossbar u_pxb_priority_pin_crossbar (
    .clk_sys(clk_sys), .reset(reset), .sfr_bus(sfr_bus),
    .sfr_rdata(sfr_rdata), .spia_four_wire(spia_four_wire),
    .spib_four_wire(spib_four_wire), .pin_output_mode(pin_output_mode),
    .pin_digital_mode(pin_digital_mode), .gpio_latch(gpio_latch),
    .periph(periph), .periph_in(periph_in), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pin_assigned(pin_assigned),
    .event_pin_level(event_pin_level), .weak_pullup_off(weak_pullup_off));
  pxb_pad_model u_pxb_pad_model (.clk_sys(clk_sys), .pin_out(pin_out),
    .pin_oe_n(pin_oe_n), .ext_drv(ext_drv), .ext_val(ext_val),
    .pull_off(weak_pullup_off), .pin_in(pin_in));

  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic stop_test;
    if (bad_count == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic sfr(input logic [7:0] a, input logic w, input logic [7:0] d);
    @(posedge clk_sys);
    sfr_bus <= '{addr: a, wr: w, rd: !w, wdata: d};
    @(posedge clk_sys);
    sfr_bus.wr <= 1'b0;
    sfr_bus.rd <= 1'b0;
    @(posedge clk_sys);
    #1;
  endtask : sfr

  task automatic check_pins;
    logic [NUM_PINS-1:0] eoe, eout, pad, asg, skip;
    logic [NUM_SIGS-1:0] pin_s, vm;
    int q [$];
    int p, s;
    logic od;
    skip = {k1[6:0], k0};
    foreach (own[i]) own[i] = -1;
    if (s0[0]) own[PIN_ASYNC_TX] = SIG_ASYNC_TX;
    if (s0[0]) own[PIN_ASYNC_RX] = SIG_ASYNC_RX;
    if (s1[6]) for (int i = 0; i < 3 + ab[0]; i++) own[8 + i] = 2 + i;
    if (s0[1]) q = {6, 7, 8};
    if (s0[1] && ab[1]) q.push_back(SIG_SPIA_NSS);
    if (s0[2]) q = {q, SIG_SDA, SIG_SCL};
    for (int j = 4; j < 8; j++) if (s0[j]) q.push_back(8 + j);
    if (s0[3]) q.push_back(SIG_CORE_CLK);
    if (s1[2:0] != CEX_RESERVED)
      for (int i = 0; i < s1[2:0]; i++) q.push_back(SIG_CEX_FIRST + i);
    for (int j = 3; j < 6; j++) if (s1[j]) q.push_back(20 + j);
    p = 0;
    foreach (q[i]) begin
      while (p < NUM_PINS && (skip[p] || own[p] >= 0)) p++;
      if (p < NUM_PINS) own[p] = q[i];
    end
    vm = '1;
    for (int i = 0; i < NUM_PINS; i++) begin
      s = own[i];
      asg[i] = s2[6] && s >= 0;
      eout[i] = asg[i] ? periph.level[s] : gpio_latch[i];
      od = !pin_output_mode[i] || s == SIG_SDA || s == SIG_SCL;
      if (asg[i]) eoe[i] = od ? !(periph.drive[s] && !eout[i])
                              : !periph.drive[s];
      else eoe[i] = od ? gpio_latch[i] : 1'b0;
      if (!s2[6] || !pin_digital_mode[i]) eoe[i] = 1'b1;
      if (asg[i] && !pin_digital_mode[i]) vm[s] = 1'b0;
      pad[i] = !eoe[i] ? eout[i] : (ext_drv[i] ? ext_val[i] : 1'b1);
    end
    pin_s = '1;
    for (int i = 0; i < NUM_PINS; i++) if (asg[i]) pin_s[own[i]] = pad[i];
    chk(pin_oe_n, eoe);
    chk(pin_out | eoe, eout | eoe);
    chk(pin_assigned, asg);
    chk(periph_in & vm, pin_s & vm);
    chk(event_pin_level, pad & pin_digital_mode);
  endtask : check_pins

  initial begin
    #100000;
    bad_count++;
    stop_test();
  end

  initial begin
    seed = 21602;
    bad_count = 0;
    compares = 0;
    reset = 1'b1;
    sfr_bus = '0;
    periph = '0;
    {spia_four_wire, spib_four_wire} = 2'h0;
    {pin_output_mode, gpio_latch, ext_drv, ext_val} = '0;
    pin_digital_mode = '1;
    repeat (8) @(posedge clk_sys);
    reset <= 1'b0;
    foreach (adr[i]) begin
      sfr(adr[i], 1'b0, 8'h00);
      chk(sfr_rdata, 8'h00);
      sfr(adr[i], 1'b1, 8'hff);
      sfr(adr[i], 1'b0, 8'h00);
      chk(sfr_rdata, msk[i]);
      chk(weak_pullup_off, adr[i] == ADDR_SEL2);
      sfr(adr[i], 1'b1, 8'h00);
    end
    sfr(8'he4, 1'b1, 8'hff);
    sfr(8'he4, 1'b0, 8'h00);
    chk(sfr_rdata, RDATA_UNMAPPED);
    for (int n = 0; n < 47; n++) begin
      if (n < 7) {ab, s0, s1, s2, k0, k1} = tbl[n];
      else begin
        {ab, s0, s1} = 24'($random(seed));
        s2 = 8'($random(seed)) & 8'h40;
        k0 = 8'($random(seed) & $random(seed));
        k1 = 8'($random(seed) & $random(seed));
      end
      @(posedge clk_sys);
      spia_four_wire <= ab[1];
      spib_four_wire <= ab[0];
      pin_output_mode <= 15'($random(seed));
      pin_digital_mode <= n < 7 ? '1 : 15'($random(seed) | $random(seed));
      gpio_latch <= 15'($random(seed));
      periph.level <= 26'($random(seed));
      periph.drive <= 26'($random(seed));
      ext_drv <= 15'($random(seed));
      ext_val <= 15'($random(seed));
      // skip masks first, as software would
      sfr(ADDR_SKIP0, 1'b1, k0);
      sfr(ADDR_SKIP1, 1'b1, k1);
      sfr(ADDR_SEL0, 1'b1, s0);
      sfr(ADDR_SEL1, 1'b1, s1);
      sfr(ADDR_SEL2, 1'b1, s2);
      repeat (4) @(posedge clk_sys);
      #1;
      check_pins();
    end
    // mid-run reset: selects clear and every pad is released at once
    @(posedge clk_sys);
    reset <= 1'b1;
    repeat (2) @(posedge clk_sys);
    #1;
    chk(pin_oe_n, {NUM_PINS{1'b1}});
    chk(pin_assigned, {NUM_PINS{1'b0}});
    chk(periph_in, {NUM_SIGS{1'b1}});
    @(posedge clk_sys);
    reset <= 1'b0;
    sfr(ADDR_SEL0, 1'b0, 8'h00);
    chk(sfr_rdata, SEL0_RST);
    sfr(ADDR_SEL2, 1'b0, 8'h00);
    chk(sfr_rdata, SEL2_RST);
    stop_test();
  end
endmodule : pxb_priority_pin_crossbar_tb

//--- src/pxb_pkg.sv
package pxb_pkg;

  // pin index 0..7 is port 0, 8..14 is port 1 bits 0..6
  localparam int NUM_PINS = 15;
  localparam int NUM_SIGS = 26;
  localparam int SIG_W = 5;

  // register addresses on the special-function register port
  localparam logic [7:0] ADDR_SEL0 = 8'he1;
  localparam logic [7:0] ADDR_SEL1 = 8'he2;
  localparam logic [7:0] ADDR_SEL2 = 8'he3;
  localparam logic [7:0] ADDR_SKIP0 = 8'hd4;
  localparam logic [7:0] ADDR_SKIP1 = 8'hd5;

  // reset values and writable-bit masks
  localparam logic [7:0] SEL0_RST = 8'h00;
  localparam logic [7:0] SEL1_RST = 8'h00;
  localparam logic [7:0] SEL2_RST = 8'h00;
  localparam logic [7:0] SKIP_RST = 8'h00;
  localparam logic [7:0] SEL1_MASK = 8'h7f;
  localparam logic [7:0] SEL2_MASK = 8'hc0;
  localparam logic [7:0] SKIP1_MASK = 8'h7f;
  localparam logic [7:0] RDATA_UNMAPPED = 8'h00;

  // crossbar_select_0 fields
  localparam int SEL0_CMP1_ASYNC = 7;
  localparam int SEL0_CMP1_SYNC = 6;
  localparam int SEL0_CMP0_ASYNC = 5;
  localparam int SEL0_CMP0_SYNC = 4;
  localparam int SEL0_CORE_CLK = 3;
  localparam int SEL0_TWO_WIRE = 2;
  localparam int SEL0_SPIA = 1;
  localparam int SEL0_ASYNC_SER = 0;
  // crossbar_select_1 fields
  localparam int SEL1_SPIB = 6;
  localparam int SEL1_TIMER_B = 5;
  localparam int SEL1_TIMER_A = 4;
  localparam int SEL1_CNT_CLK = 3;
  localparam int SEL1_CEX_LSB = 0;
  localparam int CEX_W = 3;
  localparam logic [2:0] CEX_RESERVED = 3'h7;
  // crossbar_select_2 fields
  localparam int SEL2_WEAK_PU_OFF = 7;
  localparam int SEL2_ROUTE_EN = 6;

  // fixed pin locations
  localparam int PIN_ASYNC_TX = 4;
  localparam int PIN_ASYNC_RX = 5;
  localparam int PIN_SPIB_FIRST = 8;

  // crossbar signals in descending priority
  localparam int SIG_ASYNC_TX = 0;
  localparam int SIG_ASYNC_RX = 1;
  localparam int SIG_SPIB_SCK = 2;
  localparam int SIG_SPIB_NSS = 5;
  localparam int SIG_SPIA_SCK = 6;
  localparam int SIG_SPIA_NSS = 9;
  localparam int SIG_SDA = 10;
  localparam int SIG_SCL = 11;
  localparam int SIG_CMP0_SYNC = 12;
  localparam int SIG_CMP0_ASYNC = 13;
  localparam int SIG_CMP1_SYNC = 14;
  localparam int SIG_CMP1_ASYNC = 15;
  localparam int SIG_CORE_CLK = 16;
  localparam int SIG_CEX_FIRST = 17;
  localparam int SIG_CNT_CLK = 23;
  localparam int SIG_TIMER_A = 24;
  localparam int SIG_TIMER_B = 25;
  localparam int SIG_FIRST_FLOAT = 6;

  typedef struct packed {
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [7:0] wdata;
  } pxb_sfr_type;

  typedef struct packed {
    logic [7:0] sel0;
    logic [7:0] sel1;
    logic [7:0] sel2;
    logic [NUM_PINS-1:0] skip;
  } pxb_cfg_type;

  typedef struct packed {
    logic [NUM_SIGS-1:0] level;
    logic [NUM_SIGS-1:0] drive;
  } pxb_periph_type;

endpackage : pxb_pkg

//--- src/pxb_priority_pin_crossbar.sv
`timescale 1ns/100ps
module pxb_priority_pin_crossbar import pxb_pkg::*; #(
  parameter int NPIN = NUM_PINS,
  parameter int NSIG = NUM_SIGS
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire pxb_sfr_type sfr_bus,
  output logic [7:0] sfr_rdata,
  input wire logic spia_four_wire,
  input wire logic spib_four_wire,
  input wire logic [NPIN-1:0] pin_output_mode,
  input wire logic [NPIN-1:0] pin_digital_mode,
  input wire logic [NPIN-1:0] gpio_latch,
  input wire pxb_periph_type periph,
  output logic [NSIG-1:0] periph_in,
  input wire logic [NPIN-1:0] pin_in,
  output logic [NPIN-1:0] pin_out,
  output logic [NPIN-1:0] pin_oe_n,
  output logic [NPIN-1:0] pin_assigned,
  output logic [NPIN-1:0] event_pin_level,
  output logic weak_pullup_off
);

  if (NPIN != NUM_PINS || NSIG != NUM_SIGS) begin : g_chk
    $error("crossbar: pin and signal counts are fixed by the map");
  end

  // the decoder hard-codes these relations between the pin and signal
  // maps; refuse a package that breaks them rather than misroute a pin
  if (NSIG > (1 << SIG_W)) begin : g_chk_sig_w
    $error("crossbar: signal numbers do not fit their field");
  end

  if (PIN_ASYNC_TX >= NPIN || PIN_ASYNC_RX >= NPIN) begin : g_chk_async
    $error("crossbar: async serial pins lie outside the port");
  end

  if (PIN_SPIB_FIRST + 4 > NPIN) begin : g_chk_spib
    $error("crossbar: serial B pins lie outside the port");
  end

  if (SIG_SPIB_NSS != SIG_SPIB_SCK + 3 ||
      SIG_SPIA_NSS != SIG_SPIA_SCK + 3) begin : g_chk_nss
    $error("crossbar: a select must follow its three data lines");
  end

  if (SIG_FIRST_FLOAT != SIG_SPIA_SCK ||
      SIG_SPIA_SCK != SIG_SPIB_NSS + 1) begin : g_chk_float
    $error("crossbar: floating signals must follow the fixed ones");
  end

  if (CEX_W != 3 || SIG_CEX_FIRST + 6 != SIG_CNT_CLK) begin : g_chk_cex
    $error("crossbar: counter output block does not match its field");
  end

  if (SIG_TIMER_B != NSIG - 1) begin : g_chk_last
    $error("crossbar: last signal must close the table");
  end

  typedef struct packed {
    logic [NPIN-1:0] pin_out_r;
    logic [NPIN-1:0] pin_oe_n_r;
    logic [NPIN-1:0] assigned_r;
    logic [NPIN-1:0] event_r;
    logic [NSIG-1:0] periph_in_r;
  } pxb_xbar_state_type;

  pxb_xbar_state_type st_r;
  pxb_xbar_state_type st_nxt;
  pxb_cfg_type cfg;
  logic [NPIN-1:0] pin_sync;
  logic [NSIG-1:0] sig_en;
  logic [NPIN-1:0] asg_valid;
  logic [NPIN-1:0][SIG_W-1:0] asg_sig;
  logic route_en;

  pxb_sfr_regs u_regs (
    .clk_sys(clk_sys),
    .reset(reset),
    .sfr(sfr_bus),
    .cfg(cfg),
    .rdata(sfr_rdata)
  );

  pxb_sync #(
    .WIDTH(NPIN)
  ) u_sync (
    .clk_sys(clk_sys),
    .reset(reset),
    .async_in(pin_in),
    .sync_out(pin_sync)
  );

  assign route_en = cfg.sel2[SEL2_ROUTE_EN];
  assign weak_pullup_off = cfg.sel2[SEL2_WEAK_PU_OFF];

  // which crossbar signals software has selected
  always_comb begin
    logic [2:0] cex_n;
    cex_n = cfg.sel1[SEL1_CEX_LSB +: CEX_W];
    sig_en = '0;
    sig_en[SIG_ASYNC_TX] = cfg.sel0[SEL0_ASYNC_SER];
    sig_en[SIG_ASYNC_RX] = cfg.sel0[SEL0_ASYNC_SER];
    for (int j = 0; j < 3; j++) begin
      sig_en[SIG_SPIB_SCK + j] = cfg.sel1[SEL1_SPIB];
    end
    sig_en[SIG_SPIB_NSS] = cfg.sel1[SEL1_SPIB] & spib_four_wire;
    for (int j = 0; j < 3; j++) begin
      sig_en[SIG_SPIA_SCK + j] = cfg.sel0[SEL0_SPIA];
    end
    sig_en[SIG_SPIA_NSS] = cfg.sel0[SEL0_SPIA] & spia_four_wire;
    sig_en[SIG_SDA] = cfg.sel0[SEL0_TWO_WIRE];
    sig_en[SIG_SCL] = cfg.sel0[SEL0_TWO_WIRE];
    sig_en[SIG_CMP0_SYNC] = cfg.sel0[SEL0_CMP0_SYNC];
    sig_en[SIG_CMP0_ASYNC] = cfg.sel0[SEL0_CMP0_ASYNC];
    sig_en[SIG_CMP1_SYNC] = cfg.sel0[SEL0_CMP1_SYNC];
    sig_en[SIG_CMP1_ASYNC] = cfg.sel0[SEL0_CMP1_ASYNC];
    sig_en[SIG_CORE_CLK] = cfg.sel0[SEL0_CORE_CLK];
    for (int j = 0; j < 6; j++) begin
      sig_en[SIG_CEX_FIRST + j] = (cex_n != CEX_RESERVED) &&
                                  (int'(cex_n) > j);
    end
    sig_en[SIG_CNT_CLK] = cfg.sel1[SEL1_CNT_CLK];
    sig_en[SIG_TIMER_A] = cfg.sel1[SEL1_TIMER_A];
    sig_en[SIG_TIMER_B] = cfg.sel1[SEL1_TIMER_B];
  end

  // priority decoder; purely combinational, but the pins are registered, so a
  // setting change reaches them one clock after the select register loads; a pin
  // may glitch while software rewrites selects with the crossbar enabled
  always_comb begin
    logic [NPIN-1:0] taken;
    logic found;
    taken = '0;
    found = 1'b0;
    asg_valid = '0;
    asg_sig = '0;
    if (sig_en[SIG_ASYNC_TX]) begin
      taken[PIN_ASYNC_TX] = 1'b1;
      asg_sig[PIN_ASYNC_TX] = SIG_W'(SIG_ASYNC_TX);
    end
    if (sig_en[SIG_ASYNC_RX]) begin
      taken[PIN_ASYNC_RX] = 1'b1;
      asg_sig[PIN_ASYNC_RX] = SIG_W'(SIG_ASYNC_RX);
    end
    for (int j = 0; j < 4; j++) begin
      if (sig_en[SIG_SPIB_SCK + j]) begin
        taken[PIN_SPIB_FIRST + j] = 1'b1;
        asg_sig[PIN_SPIB_FIRST + j] = SIG_W'(SIG_SPIB_SCK + j);
      end
    end
    for (int k = SIG_FIRST_FLOAT; k < NSIG; k++) begin
      found = 1'b0;
      if (sig_en[k]) begin
        for (int p = 0; p < NPIN; p++) begin
          if (!found && !taken[p] && !cfg.skip[p]) begin
            found = 1'b1;
            taken[p] = 1'b1;
            asg_sig[p] = SIG_W'(k);
          end
        end
      end
    end
    asg_valid = taken;
  end

  // pin drivers and peripheral inputs, registered
  always_comb begin
    logic [SIG_W-1:0] s;
    logic lvl;
    logic drv;
    logic open_drain;
    s = '0;
    lvl = 1'b0;
    drv = 1'b0;
    open_drain = 1'b0;
    st_nxt = st_r;
    // idle-high inputs to peripherals whose signal has no pin
    st_nxt.periph_in_r = '1;
    st_nxt.event_r = pin_sync & pin_digital_mode;
    st_nxt.assigned_r = route_en ? asg_valid : '0;
    for (int p = 0; p < NPIN; p++) begin
      s = asg_sig[p];
      if (route_en && asg_valid[p]) begin
        lvl = periph.level[s];
        drv = periph.drive[s];
        open_drain = !pin_output_mode[p] ||
                     (int'(s) == SIG_SDA) || (int'(s) == SIG_SCL);
        st_nxt.periph_in_r[s] = pin_sync[p];
      end else begin
        lvl = gpio_latch[p];
        drv = 1'b1;
        open_drain = !pin_output_mode[p];
      end
      st_nxt.pin_out_r[p] = lvl;
      if (!route_en || !pin_digital_mode[p]) begin
        st_nxt.pin_oe_n_r[p] = 1'b1;
      end else if (open_drain) begin
        st_nxt.pin_oe_n_r[p] = !(drv && !lvl);
      end else begin
        st_nxt.pin_oe_n_r[p] = !drv;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      st_r.pin_out_r <= '0;
      st_r.pin_oe_n_r <= '1;
      st_r.assigned_r <= '0;
      st_r.event_r <= '0;
      st_r.periph_in_r <= '1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign pin_out = st_r.pin_out_r;
  assign pin_oe_n = st_r.pin_oe_n_r;
  assign pin_assigned = st_r.assigned_r;
  assign event_pin_level = st_r.event_r;
  assign periph_in = st_r.periph_in_r;

endmodule : pxb_priority_pin_crossbar

//--- src/pxb_sfr_regs.sv
`timescale 1ns/100ps
module pxb_sfr_regs import pxb_pkg::*; (
  input wire logic clk_sys,
  input wire logic reset,
  input wire pxb_sfr_type sfr,
  output pxb_cfg_type cfg,
  output logic [7:0] rdata
);

  typedef struct packed {
    pxb_cfg_type cfg_r;
    logic [7:0] rdata_r;
  } pxb_regs_state_type;

  pxb_regs_state_type st_r;
  pxb_regs_state_type st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (sfr.wr) begin
      case (sfr.addr)
        ADDR_SEL0: st_nxt.cfg_r.sel0 = sfr.wdata;
        ADDR_SEL1: st_nxt.cfg_r.sel1 = sfr.wdata & SEL1_MASK;
        ADDR_SEL2: st_nxt.cfg_r.sel2 = sfr.wdata & SEL2_MASK;
        ADDR_SKIP0: st_nxt.cfg_r.skip[7:0] = sfr.wdata;
        ADDR_SKIP1: st_nxt.cfg_r.skip[NUM_PINS-1:8] = sfr.wdata[6:0];
        default: st_nxt.cfg_r = st_r.cfg_r;
      endcase
    end
    // unused bits read back as zero
    if (sfr.rd) begin
      case (sfr.addr)
        ADDR_SEL0: st_nxt.rdata_r = st_r.cfg_r.sel0;
        ADDR_SEL1: st_nxt.rdata_r = st_r.cfg_r.sel1;
        ADDR_SEL2: st_nxt.rdata_r = st_r.cfg_r.sel2;
        ADDR_SKIP0: st_nxt.rdata_r = st_r.cfg_r.skip[7:0];
        ADDR_SKIP1: st_nxt.rdata_r = {1'b0, st_r.cfg_r.skip[NUM_PINS-1:8]};
        default: st_nxt.rdata_r = RDATA_UNMAPPED;
      endcase
    end
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      st_r.cfg_r.sel0 <= SEL0_RST;
      st_r.cfg_r.sel1 <= SEL1_RST;
      st_r.cfg_r.sel2 <= SEL2_RST;
      st_r.cfg_r.skip <= {SKIP_RST[6:0], SKIP_RST};
      st_r.rdata_r <= RDATA_UNMAPPED;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign cfg = st_r.cfg_r;
  assign rdata = st_r.rdata_r;

endmodule : pxb_sfr_regs

//--- src/pxb_sync.sv
`timescale 1ns/100ps
module pxb_sync import pxb_pkg::*; #(
  parameter int WIDTH = NUM_PINS
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  typedef struct packed {
    logic [WIDTH-1:0] stage1_r;
    logic [WIDTH-1:0] stage2_r;
  } pxb_sync_state_type;

  pxb_sync_state_type st_r;
  pxb_sync_state_type st_nxt;

  if (WIDTH < 1) begin : g_chk
    $error("pxb_sync: WIDTH must be at least one");
  end

  // first stage feeds only the second stage
  always_comb begin
    st_nxt.stage1_r = async_in;
    st_nxt.stage2_r = st_r.stage1_r;
  end

  always_ff @(posedge clk_sys or posedge reset) begin
    if (reset) begin
      st_r <= '1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign sync_out = st_r.stage2_r;

endmodule : pxb_sync
